// ===== design/iq_pol_pkg.sv
// ****************************************************************
// Shared constants of the configuration register bank
// ****************************************************************
package iq_pol_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned NUM_REGS = 10;
  localparam int unsigned NUM_CHANS = 2;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_RESTART = 8'h00;
  localparam logic [7:0] ADDR_ENABLES = 8'h01;
  localparam logic [7:0] ADDR_WHOLE_DIV = 8'h02;
  localparam logic [7:0] ADDR_FRAC_NUM = 8'h03;
  localparam logic [7:0] ADDR_FRAC_MOD = 8'h04;
  localparam logic [7:0] ADDR_PD_MASK = 8'h10;
  localparam logic [7:0] ADDR_CHARGE_PUMP = 8'h20;
  localparam logic [7:0] ADDR_PHASE_DET = 8'h21;
  localparam logic [7:0] ADDR_OSC = 8'h22;
  localparam logic [7:0] ADDR_RF_SWITCH = 8'h23;
  localparam logic [7:0] ADDR_MOD_CTRL0 = 8'h32;

  // ****************************************************************
  // Storage slot of each register inside the bank
  // ****************************************************************
  localparam int unsigned IDX_ENABLES = 0;
  localparam int unsigned IDX_WHOLE_DIV = 1;
  localparam int unsigned IDX_FRAC_NUM = 2;
  localparam int unsigned IDX_FRAC_MOD = 3;
  localparam int unsigned IDX_PD_MASK = 4;
  localparam int unsigned IDX_CHARGE_PUMP = 5;
  localparam int unsigned IDX_PHASE_DET = 6;
  localparam int unsigned IDX_OSC = 7;
  localparam int unsigned IDX_RF_SWITCH = 8;
  localparam int unsigned IDX_MOD_CTRL0 = 9;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [15:0] RST_ENABLES = 16'hFE7F;
  localparam logic [15:0] RST_WHOLE_DIV = 16'h002C;
  localparam logic [15:0] RST_FRAC_NUM = 16'h0128;
  localparam logic [15:0] RST_FRAC_MOD = 16'h0600;
  localparam logic [15:0] RST_PD_MASK = 16'hFE7F;
  localparam logic [15:0] RST_CHARGE_PUMP = 16'h0C26;
  localparam logic [15:0] RST_PHASE_DET = 16'h0003;
  localparam logic [15:0] RST_OSC = 16'h2A03;
  localparam logic [15:0] RST_RF_SWITCH = 16'h0000;
  localparam logic [15:0] RST_MOD_CTRL0 = 16'h0900;

  // Bits 15:12 of the modulator control word are reserved and read zero
  localparam logic [15:0] MASK_MOD_CTRL0 = 16'h0FFF;
  localparam logic [15:0] MASK_FULL = 16'hFFFF;

  // ****************************************************************
  // Field positions and encodings
  // ****************************************************************
  localparam int unsigned RESTART_BIT = 0;
  localparam int unsigned POL_W = 2;
  localparam int unsigned IPOL_LSB = 8;
  localparam int unsigned QPOL_LSB = 10;
  localparam logic [1:0] IPOL_NORMAL = 2'h1;
  localparam logic [1:0] IPOL_INVERT = 2'h2;
  localparam logic [1:0] QPOL_NORMAL = 2'h2;
  localparam logic [1:0] QPOL_INVERT = 2'h1;

  // ****************************************************************
  // Bank tables, one entry per storage slot
  // ****************************************************************
  localparam logic [7:0] BANK_ADDR [NUM_REGS] = '{
    ADDR_ENABLES, ADDR_WHOLE_DIV, ADDR_FRAC_NUM, ADDR_FRAC_MOD, ADDR_PD_MASK,
    ADDR_CHARGE_PUMP, ADDR_PHASE_DET, ADDR_OSC, ADDR_RF_SWITCH, ADDR_MOD_CTRL0};
  localparam logic [15:0] BANK_RST [NUM_REGS] = '{
    RST_ENABLES, RST_WHOLE_DIV, RST_FRAC_NUM, RST_FRAC_MOD, RST_PD_MASK,
    RST_CHARGE_PUMP, RST_PHASE_DET, RST_OSC, RST_RF_SWITCH, RST_MOD_CTRL0};
  localparam logic [15:0] BANK_MASK [NUM_REGS] = '{
    MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
    MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_MOD_CTRL0};

endpackage

// ===== design/iq_polarity_stage.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Registered sign stage for the in-phase and quadrature samples
// ****************************************************************
module iq_polarity_stage (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Samples in
  input wire logic [iq_pol_pkg::NUM_CHANS-1:0][iq_pol_pkg::SAMPLE_W-1:0] data_in,
  input wire logic valid_in,
  input wire logic [iq_pol_pkg::NUM_CHANS-1:0] invert_in,
  // Samples out
  output logic [iq_pol_pkg::NUM_CHANS-1:0][iq_pol_pkg::SAMPLE_W-1:0] data_out,
  output logic valid_out
);
  import iq_pol_pkg::*;

  localparam logic [SAMPLE_W-1:0] MOST_NEG = {1'b1, {(SAMPLE_W-1){1'b0}}};
  localparam logic [SAMPLE_W-1:0] MOST_POS = {1'b0, {(SAMPLE_W-1){1'b1}}};

  logic valid_q;

  // ****************************************************************
  // Per channel negation, saturating the one value with no opposite
  // ****************************************************************
  for (genvar c = 0; c < NUM_CHANS; c++) begin : g_chan
    logic [SAMPLE_W-1:0] neg_d;
    logic [SAMPLE_W-1:0] sel_d;
    logic [SAMPLE_W-1:0] data_q;
    assign neg_d = (data_in[c] == MOST_NEG) ? MOST_POS : SAMPLE_W'(-data_in[c]);
    assign sel_d = invert_in[c] ? neg_d : data_in[c];
    // Holds the last sample between valid strobes
    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        data_q <= '0;
      end else if (valid_in) begin
        data_q <= sel_d;
      end
    end
    assign data_out[c] = data_q;
  end

  // Valid follows the samples by one cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_in;
    end
  end
  assign valid_out = valid_q;

endmodule
`default_nettype wire

// ===== design/iq_polarity_config_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: In-phase polarity field at control word bits 9:8
// RULE2: Quadrature polarity field at bits 11:10, independent
// RULE3: In-phase: 1 normal, 2 inverted
// RULE4: Quadrature: 2 normal, 1 inverted
// RULE5: Reset leaves both polarity fields at normal
module iq_polarity_config_bank (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // Register access port
  input wire logic [iq_pol_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [iq_pol_pkg::REG_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [iq_pol_pkg::REG_W-1:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  // Baseband samples in
  input wire logic [iq_pol_pkg::SAMPLE_W-1:0] I_DATA_IN,
  input wire logic [iq_pol_pkg::SAMPLE_W-1:0] Q_DATA_IN,
  input wire logic SAMPLE_VALID_IN,
  // Baseband samples out
  output logic [iq_pol_pkg::SAMPLE_W-1:0] I_DATA_OUT,
  output logic [iq_pol_pkg::SAMPLE_W-1:0] Q_DATA_OUT,
  output logic SAMPLE_VALID_OUT,
  // Polarity state
  output logic I_INVERTED_OUT,
  output logic Q_INVERTED_OUT,
  // Configuration words toward the analog blocks
  output logic [iq_pol_pkg::REG_W-1:0] BLOCK_ENABLES_OUT,
  output logic [iq_pol_pkg::REG_W-1:0] WHOLE_DIVIDER_OUT,
  output logic [iq_pol_pkg::REG_W-1:0] FRACTION_NUMERATOR_OUT,
  output logic [iq_pol_pkg::REG_W-1:0] FRACTION_MODULUS_OUT,
  output logic [iq_pol_pkg::REG_W-1:0] POWER_DOWN_MASK_OUT,
  output logic [iq_pol_pkg::REG_W-1:0] CHARGE_PUMP_OUT,
  output logic [iq_pol_pkg::REG_W-1:0] PHASE_DETECTOR_OUT,
  output logic [iq_pol_pkg::REG_W-1:0] OSCILLATOR_OUT,
  output logic [iq_pol_pkg::REG_W-1:0] RF_SWITCH_ATTEN_OUT
);
  import iq_pol_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [REG_W-1:0] bank_q [NUM_REGS];
  logic [NUM_REGS-1:0] slot_hit;
  logic [NUM_REGS-1:0] slot_wr;
  logic [NUM_REGS-1:0][REG_W-1:0] slot_word;
  logic [NUM_REGS-1:0][REG_W-1:0] read_term;
  logic restart_addr_hit;
  logic restart_hit;
  logic any_hit;
  logic [REG_W-1:0] read_mux;
  logic [REG_W-1:0] rdata_q;
  logic [REG_W-1:0] rdata_d;
  logic rvalid_q;
  logic [POL_W-1:0] in_phase_polarity_sel;
  logic [POL_W-1:0] quadrature_polarity_sel;
  logic i_invert_d;
  logic q_invert_d;
  logic i_inv_q;
  logic q_inv_q;
  logic [NUM_CHANS-1:0] chan_invert;
  logic [NUM_CHANS-1:0][SAMPLE_W-1:0] chan_data_in;
  logic [NUM_CHANS-1:0][SAMPLE_W-1:0] chan_data_out;

  // ****************************************************************
  // Software restart decode
  // ****************************************************************
  // A write to the restart register with bit 0 set returns every
  // stored register to its value after reset on the next edge.
  // Writes with bit 0 clear have no effect; the register reads zero.
  assign restart_addr_hit = REG_WR_IN && (REG_ADDR_IN == ADDR_RESTART);
  assign restart_hit = restart_addr_hit && REG_WDATA_IN[RESTART_BIT];

  // ****************************************************************
  // Register storage, one slot per mapped word
  // ****************************************************************
  for (genvar r = 0; r < NUM_REGS; r++) begin : g_slot
    // Offset match of this slot, shared by the write and read paths
    assign slot_hit[r] = (REG_ADDR_IN == BANK_ADDR[r]);
    assign slot_wr[r] = REG_WR_IN && slot_hit[r];
    // Reserved bits are masked away so they always store zero
    assign slot_word[r] = REG_WDATA_IN & BANK_MASK[r];
    // Read contribution, zero unless this slot is addressed
    assign read_term[r] = slot_hit[r] ? bank_q[r] : '0;
    // Restart wins over any write presented in the same cycle
    always_ff @(posedge CLOCK_IN) begin
      if (SRST_IN || restart_hit) begin
        bank_q[r] <= BANK_RST[r]; // RULE5
      end else if (slot_wr[r]) begin
        bank_q[r] <= slot_word[r];
      end
    end
  end

  assign any_hit = |slot_hit;

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Slots have distinct offsets, so at most one term is non-zero;
  // the OR is taken bit by bit across all slots
  for (genvar b = 0; b < REG_W; b++) begin : g_read_bit
    logic [NUM_REGS-1:0] bit_terms;
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_term
      assign bit_terms[r] = read_term[r][b];
    end
    assign read_mux[b] = |bit_terms;
  end

  // Restart register and unmapped offsets read as zero
  assign rdata_d = any_hit ? read_mux : '0;

  // ****************************************************************
  // Read answer registers
  // ****************************************************************
  // Not cleared by a soft restart, only by the reset pin
  // Read data is held until the next read strobe
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      rdata_q <= '0;
    end else if (REG_RD_IN) begin
      rdata_q <= rdata_d;
    end
  end

  // Read valid marks the cycle after each read strobe
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD_IN;
    end
  end

  assign REG_RDATA_OUT = rdata_q;
  assign REG_RVALID_OUT = rvalid_q;

  // ****************************************************************
  // Polarity field extraction and decode
  // ****************************************************************
  // In-phase selector sits in bits 9:8 of the modulator control word
  assign in_phase_polarity_sel = bank_q[IDX_MOD_CTRL0][IPOL_LSB +: POL_W]; // RULE1
  // Quadrature selector sits in bits 11:10, decoded on its own
  assign quadrature_polarity_sel = bank_q[IDX_MOD_CTRL0][QPOL_LSB +: POL_W]; // RULE2

  // Only the invert code flips a channel; codes 0 and 3 leave it normal
  assign i_invert_d = (in_phase_polarity_sel == IPOL_INVERT); // RULE3
  assign q_invert_d = (quadrature_polarity_sel == QPOL_INVERT); // RULE4

  // ****************************************************************
  // Polarity state registers
  // ****************************************************************
  // Registered in-phase state, driven out on I_INVERTED_OUT and not readable through the register port
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      i_inv_q <= 1'b0; // RULE5
    end else begin
      i_inv_q <= i_invert_d; // RULE3
    end
  end

  // Registered quadrature state, kept apart from the in-phase one
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      q_inv_q <= 1'b0; // RULE5
    end else begin
      q_inv_q <= q_invert_d; // RULE4
    end
  end

  assign I_INVERTED_OUT = i_inv_q;
  assign Q_INVERTED_OUT = q_inv_q;

  // ****************************************************************
  // Baseband sign stage
  // ****************************************************************
  // Channel 0 carries in-phase, channel 1 carries quadrature; the
  // decoded inversion is used directly so a change takes effect on
  // the first sample after the write edge.
  // The state flags lag this path by one cycle, so they change on
  // the same edge as the first output sample with the new sign.
  assign chan_invert = {q_invert_d, i_invert_d}; // RULE2
  assign chan_data_in = {Q_DATA_IN, I_DATA_IN};

  iq_polarity_stage u_stage (
    .clk_in(CLOCK_IN),
    .srst_in(SRST_IN),
    .data_in(chan_data_in),
    .valid_in(SAMPLE_VALID_IN),
    .invert_in(chan_invert),
    .data_out(chan_data_out),
    .valid_out(SAMPLE_VALID_OUT)
  );

  assign I_DATA_OUT = chan_data_out[0];
  assign Q_DATA_OUT = chan_data_out[1];

  // ****************************************************************
  // Configuration words, each straight from its storage slot
  // ****************************************************************
  assign BLOCK_ENABLES_OUT = bank_q[IDX_ENABLES];
  assign WHOLE_DIVIDER_OUT = bank_q[IDX_WHOLE_DIV];
  assign FRACTION_NUMERATOR_OUT = bank_q[IDX_FRAC_NUM];
  assign FRACTION_MODULUS_OUT = bank_q[IDX_FRAC_MOD];
  assign POWER_DOWN_MASK_OUT = bank_q[IDX_PD_MASK];

  // Loop, oscillator and input switch settings
  assign CHARGE_PUMP_OUT = bank_q[IDX_CHARGE_PUMP];
  assign PHASE_DETECTOR_OUT = bank_q[IDX_PHASE_DET];
  assign OSCILLATOR_OUT = bank_q[IDX_OSC];
  assign RF_SWITCH_ATTEN_OUT = bank_q[IDX_RF_SWITCH];

endmodule
`default_nettype wire

// ===== test/iq_polarity_config_bank_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker of the register bank
// ****************************************
module iq_polarity_config_bank_props import iq_pol_pkg::*; (
  // Clock, reset and register port
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [REG_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [REG_W-1:0] REG_RDATA_OUT,
  input wire logic REG_RVALID_OUT,
  // Samples and state
  input wire logic SAMPLE_VALID_IN,
  input wire logic [SAMPLE_W-1:0] I_DATA_OUT,
  input wire logic [SAMPLE_W-1:0] Q_DATA_OUT,
  input wire logic SAMPLE_VALID_OUT,
  input wire logic I_INVERTED_OUT,
  input wire logic Q_INVERTED_OUT,
  input wire logic [REG_W-1:0] BLOCK_ENABLES_OUT,
  input wire logic [REG_W-1:0] CHARGE_PUMP_OUT,
  input wire logic [REG_W-1:0] OSCILLATOR_OUT
);
  // One clock domain
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);

  a_read_answer: assert property (REG_RD_IN |=> REG_RVALID_OUT)
    else $error("read strobe got no answer");
  a_rvalid_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN))
    else $error("read valid without a read");
  a_rdata_hold: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
    else $error("read data moved without a read");
  a_sample_delay: assert property (SAMPLE_VALID_IN |=> SAMPLE_VALID_OUT)
    else $error("sample valid not delayed by one");
  a_sample_hold: assert property (!SAMPLE_VALID_IN |=> $stable(I_DATA_OUT) && $stable(Q_DATA_OUT))
    else $error("sample data moved without a strobe");
  a_sample_cause: assert property (SAMPLE_VALID_OUT |-> $past(SAMPLE_VALID_IN))
    else $error("sample valid without a strobe");
  a_reset_state: assert property (
    $fell(SRST_IN) |-> !I_INVERTED_OUT && !Q_INVERTED_OUT && BLOCK_ENABLES_OUT == RST_ENABLES)
    else $error("state after reset wrong");
  a_i_pol_flag: assert property (
    REG_WR_IN && REG_ADDR_IN == ADDR_MOD_CTRL0 |=> ##1
      I_INVERTED_OUT == ($past(REG_WDATA_IN[9:8], 2) == IPOL_INVERT))
    else $error("in-phase flag does not follow its code");
  a_q_pol_flag: assert property (
    REG_WR_IN && REG_ADDR_IN == ADDR_MOD_CTRL0 |=> ##1
      Q_INVERTED_OUT == ($past(REG_WDATA_IN[11:10], 2) == QPOL_INVERT))
    else $error("quadrature flag does not follow its code");
  a_restart_reload: assert property (
    REG_WR_IN && REG_ADDR_IN == ADDR_RESTART && REG_WDATA_IN[0] |=>
      OSCILLATOR_OUT == RST_OSC && CHARGE_PUMP_OUT == RST_CHARGE_PUMP)
    else $error("soft restart did not reload");
  a_restart_flags: assert property (
    REG_WR_IN && REG_ADDR_IN == ADDR_RESTART && REG_WDATA_IN[0] |=> ##1
      !I_INVERTED_OUT && !Q_INVERTED_OUT)
    else $error("soft restart left a channel inverted");
endmodule
bind iq_polarity_config_bank iq_polarity_config_bank_props u_props (
  .CLOCK_IN(CLOCK_IN),
  .SRST_IN(SRST_IN),
  .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN),
  .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT),
  .REG_RVALID_OUT(REG_RVALID_OUT),
  .SAMPLE_VALID_IN(SAMPLE_VALID_IN),
  .I_DATA_OUT(I_DATA_OUT),
  .Q_DATA_OUT(Q_DATA_OUT),
  .SAMPLE_VALID_OUT(SAMPLE_VALID_OUT),
  .I_INVERTED_OUT(I_INVERTED_OUT),
  .Q_INVERTED_OUT(Q_INVERTED_OUT),
  .BLOCK_ENABLES_OUT(BLOCK_ENABLES_OUT),
  .CHARGE_PUMP_OUT(CHARGE_PUMP_OUT),
  .OSCILLATOR_OUT(OSCILLATOR_OUT)
);
`default_nettype wire

// ===== test/iq_polarity_config_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Self-checking bench of the register bank
// ****************************************
module iq_polarity_config_bank_bench;
  import iq_pol_pkg::*;
  logic CLOCK_IN = 0, SRST_IN = 1, REG_WR_IN = 0, REG_RD_IN = 0, SAMPLE_VALID_IN = 0;
  logic [7:0] REG_ADDR_IN = 8'h00;
  logic [15:0] REG_WDATA_IN = 16'h0000, I_DATA_IN = 16'h0000, Q_DATA_IN = 16'h0000;
  logic [15:0] REG_RDATA_OUT, I_DATA_OUT, Q_DATA_OUT, BLOCK_ENABLES_OUT, WHOLE_DIVIDER_OUT;
  logic [15:0] FRACTION_NUMERATOR_OUT, FRACTION_MODULUS_OUT, POWER_DOWN_MASK_OUT;
  logic [15:0] CHARGE_PUMP_OUT, PHASE_DETECTOR_OUT, OSCILLATOR_OUT, RF_SWITCH_ATTEN_OUT;
  logic REG_RVALID_OUT, SAMPLE_VALID_OUT, I_INVERTED_OUT, Q_INVERTED_OUT;
  int mismatches = 0, num_checks = 0, cyc = 0;
  logic [31:0] seed = 32'h74EF555F;
  logic [15:0] m [NUM_REGS];

  iq_polarity_config_bank uut (
    .CLOCK_IN(CLOCK_IN),
    .SRST_IN(SRST_IN),
    .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN),
    .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT),
    .REG_RVALID_OUT(REG_RVALID_OUT),
    .I_DATA_IN(I_DATA_IN),
    .Q_DATA_IN(Q_DATA_IN),
    .SAMPLE_VALID_IN(SAMPLE_VALID_IN),
    .I_DATA_OUT(I_DATA_OUT),
    .Q_DATA_OUT(Q_DATA_OUT),
    .SAMPLE_VALID_OUT(SAMPLE_VALID_OUT),
    .I_INVERTED_OUT(I_INVERTED_OUT),
    .Q_INVERTED_OUT(Q_INVERTED_OUT),
    .BLOCK_ENABLES_OUT(BLOCK_ENABLES_OUT),
    .WHOLE_DIVIDER_OUT(WHOLE_DIVIDER_OUT),
    .FRACTION_NUMERATOR_OUT(FRACTION_NUMERATOR_OUT),
    .FRACTION_MODULUS_OUT(FRACTION_MODULUS_OUT),
    .POWER_DOWN_MASK_OUT(POWER_DOWN_MASK_OUT),
    .CHARGE_PUMP_OUT(CHARGE_PUMP_OUT),
    .PHASE_DETECTOR_OUT(PHASE_DETECTOR_OUT),
    .OSCILLATOR_OUT(OSCILLATOR_OUT),
    .RF_SWITCH_ATTEN_OUT(RF_SWITCH_ATTEN_OUT)
  );

  // Clock and hang limit
  always #10 CLOCK_IN = ~CLOCK_IN;
  always @(posedge CLOCK_IN) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function logic [15:0] pol(input logic [15:0] x, input logic inv);
    return !inv ? x : (x == 16'h8000 ? 16'h7FFF : -x);
  endfunction
  function logic [15:0] look(input logic [7:0] a);
    look = 16'h0000;
    for (int i = 0; i < NUM_REGS; i++) if (BANK_ADDR[i] == a) look = m[i];
  endfunction
  task chk(input string n, input logic [143:0] e, input logic [143:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Register write, model follows
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge CLOCK_IN);
    REG_ADDR_IN = a;
    REG_WDATA_IN = d;
    REG_WR_IN = 1;
    @(negedge CLOCK_IN);
    REG_WR_IN = 0;
    for (int i = 0; i < NUM_REGS; i++) if (BANK_ADDR[i] == a) m[i] = d & BANK_MASK[i];
    if (a == ADDR_RESTART && d[RESTART_BIT]) m = BANK_RST;
  endtask
  task rd(input logic [7:0] a);
    @(negedge CLOCK_IN);
    REG_ADDR_IN = a;
    REG_RD_IN = 1;
    @(negedge CLOCK_IN);
    REG_RD_IN = 0;
    chk("rdata", {1'b1, look(a)}, {REG_RVALID_OUT, REG_RDATA_OUT});
  endtask
  // One sample pair, then the state flags a cycle later
  task samp(input logic [15:0] i, input logic [15:0] q);
    logic ii, qi;
    ii = m[IDX_MOD_CTRL0][IPOL_LSB +: POL_W] == IPOL_INVERT;
    qi = m[IDX_MOD_CTRL0][QPOL_LSB +: POL_W] == QPOL_INVERT;
    @(negedge CLOCK_IN);
    I_DATA_IN = i;
    Q_DATA_IN = q;
    SAMPLE_VALID_IN = 1;
    @(negedge CLOCK_IN);
    SAMPLE_VALID_IN = 0;
    chk("sample", {1'b1, pol(i, ii), pol(q, qi)}, {SAMPLE_VALID_OUT, I_DATA_OUT, Q_DATA_OUT});
    @(negedge CLOCK_IN);
    chk("flags", {ii, qi}, {I_INVERTED_OUT, Q_INVERTED_OUT});
  endtask
  task cfg();
    logic [143:0] e;
    for (int i = 0; i < 9; i++) e[143-16*i -: 16] = m[i];
    chk("config", e, {BLOCK_ENABLES_OUT, WHOLE_DIVIDER_OUT, FRACTION_NUMERATOR_OUT,
      FRACTION_MODULUS_OUT, POWER_DOWN_MASK_OUT, CHARGE_PUMP_OUT, PHASE_DETECTOR_OUT,
      OSCILLATOR_OUT, RF_SWITCH_ATTEN_OUT});
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] d;
    m = BANK_RST;
    repeat (6) @(negedge CLOCK_IN);
    SRST_IN = 0;
    cfg();
    for (int i = 0; i < NUM_REGS; i++) rd(BANK_ADDR[i]);
    rd(ADDR_RESTART);
    rd(8'h05);
    samp(16'h8000, 16'h7FFF);
    $display("test reset values done");
    for (int k = 0; k < 16; k++) begin
      d = rnd();
      d[11:8] = 4'(k);
      wr(ADDR_MOD_CTRL0, d);
      rd(ADDR_MOD_CTRL0);
      samp(k == 10 ? 16'h8000 : rnd(), k == 5 ? 16'h8000 : rnd());
    end
    $display("test polarity codes done");
    for (int i = 0; i < NUM_REGS; i++) wr(BANK_ADDR[i], rnd());
    wr(8'h05, rnd());
    cfg();
    for (int i = 0; i < NUM_REGS; i++) rd(BANK_ADDR[i]);
    rd(8'h05);
    $display("test random words done");
    wr(ADDR_RESTART, 16'hFFFE);
    cfg();
    wr(ADDR_RESTART, 16'h0001);
    cfg();
    rd(ADDR_MOD_CTRL0);
    samp(rnd(), rnd());
    $display("test soft restart done");
    complete_run();
  end
endmodule
`default_nettype wire
